// File: design/cms_ms_timer.sv
// millisecond elapsed-time counter, restarted whenever its run level drops
`timescale 1ns/1ps
module cms_ms_timer #(
	parameter int unsigned P_CYC_PER_MS = cms_pkg::MS_CYC
) (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_rst_n,
	// control
	input wire logic i_run,
	// elapsed milliseconds, saturating
	output logic [cms_pkg::MS_W-1:0] o_ms
);
	logic [cms_pkg::DIV_W-1:0] div_reg, div_next;
	logic [cms_pkg::MS_W-1:0] ms_reg, ms_next;
	localparam logic [cms_pkg::DIV_W-1:0] DIV_LAST = cms_pkg::DIV_W'(P_CYC_PER_MS - 1);

	// divider makes a one-cycle ms enable; saturation stops wrap-around false timeouts
	always_comb begin
		div_next = div_reg;
		ms_next = ms_reg;
		if (!i_run) begin
			div_next = '0;
			ms_next = '0;
		end else if (div_reg == DIV_LAST) begin
			div_next = '0;
			if (ms_reg != '1)
				ms_next = ms_reg + 1'b1;
		end else begin
			div_next = div_reg + 1'b1;
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			div_reg <= '0;
			ms_reg <= '0;
		end else begin
			div_reg <= div_next;
			ms_reg <= ms_next;
		end
	end

	assign o_ms = ms_reg;
endmodule // cms_ms_timer

// File: design/cms_pkg.sv
// constants shared by the charger mode sequencer and its millisecond timer
package cms_pkg;
	// clock and timing
	localparam int unsigned CLK_HZ = 250_000_000;
	localparam int unsigned MS_CYC = CLK_HZ / 1000;
	localparam int DIV_W = 18;
	localparam int MS_W = 8;
	localparam logic [7:0] T_REG_ON_MS = 8'h32; // 50 ms
	localparam logic [7:0] T_CONV_ON_MS = 8'h96; // 150 ms
	localparam logic [7:0] T_REV_ON_MS = 8'h0A; // 10 ms
	// input limits in mA / mV
	localparam logic [15:0] IIN_DEFAULT_MA = 16'h0CB2;
	localparam logic [15:0] FLOOR_OFFSET_MV = 16'h0500;
	localparam logic [15:0] REV_OFFSET_MV = 16'h0500;
	localparam logic [15:0] REV_BASE_MV = 16'h0BB8;
	localparam logic [15:0] REV_LSB_MV = 16'h0008;
	// droop thresholds: base plus field times step
	localparam logic [15:0] TH1_BASE_MV = 16'h170C;
	localparam logic [15:0] TH1_STEP_MV = 16'h0064;
	localparam logic [15:0] TH2_BASE_MV = 16'h170C;
	localparam logic [15:0] TH2_STEP_MV = 16'h0064;
	// cell-count pin ratio, percent of regulator voltage
	localparam logic [6:0] CELL4_MIN_PCT = 7'h42;
	localparam logic [6:0] CELL3_MIN_PCT = 7'h32;
	localparam logic [6:0] CELL2_MIN_PCT = 7'h21;
	localparam logic [6:0] BAT_PRES_RISE_PCT = 7'h12;
	localparam logic [6:0] BAT_PRES_FALL_PCT = 7'h0F;
	// per cell count: charge voltage and system overvoltage defaults
	localparam logic [15:0] CHG4_MV = 16'h41A0;
	localparam logic [15:0] CHG3_MV = 16'h3130;
	localparam logic [15:0] CHG2_MV = 16'h20D0;
	localparam logic [15:0] CHG1_MV = 16'h1060;
	localparam logic [15:0] SOV4_MV = 16'h4C2C;
	localparam logic [15:0] SOV3_MV = 16'h4C2C;
	localparam logic [15:0] SOV2_MV = 16'h2EE0;
	localparam logic [15:0] SOV1_MV = 16'h1388;
	// reset values of control bits
	localparam logic LOW_POWER_RST = 1'b1;
	localparam logic ASSIST_OFF_RST = 1'b1;
	// power-up sequence states
	typedef enum logic [1:0] {PU_OFF, PU_WAIT, PU_SETUP, PU_RUN} cms_pu_e;
endpackage

// File: design/cms_sequencer.sv
// charger mode and power-up sequencer: low-power, assist, DC power-up, hi-z and reverse output control
`timescale 1ns/1ps
module cms_sequencer #(
	parameter int unsigned P_CYC_PER_MS = cms_pkg::MS_CYC
) (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_rst_n,
	// comparator levels from the analog front end (asynchronous)
	input wire logic i_vbat_above_release,
	input wire logic i_vbus_above_conv_en,
	input wire logic i_vbus_below_ovp,
	input wire logic i_vbus_below_conv_off,
	input wire logic i_fault_any,
	input wire logic i_battery_overvoltage_trip,
	input wire logic i_limit_pin_below_hiz,
	input wire logic i_analog_supply_ready,
	// host pins (asynchronous)
	input wire logic i_reverse_assist_mode_pin,
	input wire logic i_reverse_enable_pin,
	// measurements from the converter ADC, same clock
	input wire logic [15:0] i_vbus_noload_mv,
	input wire logic [15:0] i_system_rail_mv,
	input wire logic [15:0] i_limit_pin_ma,
	input wire logic [6:0] i_cell_pin_pct,
	// host configuration, same clock; i_cfg_wr loads the control bits
	input wire logic i_cfg_wr,
	input wire logic i_cfg_low_power,
	input wire logic i_cfg_assist_off,
	input wire logic i_cfg_reverse_sel,
	input wire logic i_cfg_hiz,
	input wire logic i_cfg_reverse_range,
	input wire logic i_cfg_ok_in_reverse,
	input wire logic [3:0] i_cfg_feature_en,
	input wire logic i_iin_wr,
	input wire logic [15:0] i_iin_ma,
	input wire logic [11:0] i_reverse_voltage_code,
	input wire logic [7:0] i_reverse_current_code,
	input wire logic [5:0] i_min_sys_point,
	input wire logic [3:0] i_first_droop_threshold,
	input wire logic [1:0] i_second_droop_threshold,
	// power path and regulator controls
	output logic o_battery_switch_on,
	output logic o_gate_drive_regulator_en,
	output logic o_regulator_6v_en,
	output logic o_converter_en,
	output logic o_low_power_mode,
	output logic o_hiz,
	output logic [3:0] o_feature_en,
	// capacitor assist
	output logic o_capacitor_assist_mode,
	output logic o_assist_discharge,
	output logic [5:0] o_min_sys_point,
	output logic o_assist_off_bit,
	// open-drain pins, enable high pulls low
	output logic o_processor_hot_alert_o,
	output logic o_processor_hot_alert_oe,
	output logic o_charger_ok_output_o,
	output logic o_charger_ok_output_oe,
	// limits and defaults
	output logic [15:0] o_iin_reg_ma,
	output logic [15:0] o_iin_eff_ma,
	output logic [15:0] o_input_voltage_floor_mv,
	output logic [2:0] o_cell_count,
	output logic [15:0] o_charge_voltage_mv,
	output logic [15:0] o_system_overvoltage_limit_mv,
	output logic o_battery_present,
	// reverse output
	output logic o_reverse_active,
	output logic [15:0] o_reverse_output_voltage_mv,
	output logic [7:0] o_reverse_current_code
);
	// reset release through two flops
	logic rst_q1, rst_n;
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			rst_q1 <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_q1 <= 1'b1;
			rst_n <= rst_q1;
		end
	end

	// pin synchronisers; only the second stage is read
	localparam int N_SYNC = 10;
	logic [N_SYNC-1:0] pin_raw, sync_q1, sync_q2;
	assign pin_raw = {i_vbat_above_release, i_vbus_above_conv_en, i_vbus_below_ovp, i_vbus_below_conv_off,
		i_fault_any, i_battery_overvoltage_trip, i_limit_pin_below_hiz, i_analog_supply_ready,
		i_reverse_assist_mode_pin, i_reverse_enable_pin};
	always_ff @(posedge i_clk or negedge rst_n) begin
		if (!rst_n) begin
			sync_q1 <= '0;
			sync_q2 <= '0;
		end else begin
			sync_q1 <= pin_raw;
			sync_q2 <= sync_q1;
		end
	end
	logic vbat_ok, vbus_on, vbus_below_ovp, vbus_off, fault, bat_ovp, lim_low, avdd_rdy, mode_pin, rev_pin;
	assign {vbat_ok, vbus_on, vbus_below_ovp, vbus_off, fault, bat_ovp, lim_low, avdd_rdy, mode_pin, rev_pin} = sync_q2;

	// control bits written by the host
	logic low_power_reg, low_power_next, assist_off_reg, assist_off_next;
	logic rev_sel_reg, rev_sel_next, hiz_bit_reg, hiz_bit_next;
	logic range_reg, range_next, ok_rev_reg, ok_rev_next;
	logic [3:0] feat_reg, feat_next;
	// sequence state
	cms_pkg::cms_pu_e pu_reg, pu_next;
	logic reg6_reg, reg6_next, conv_fwd_reg, conv_fwd_next;
	logic ok_reg, ok_next, cells_done_reg, cells_done_next, rev_run_reg, rev_run_next;
	logic [15:0] iin_reg, iin_next, floor_reg, floor_next, chg_reg, chg_next, sov_reg, sov_next;
	logic [2:0] cells_reg, cells_next;
	logic bat_pres_reg, bat_pres_next;
	// registered outputs
	logic bsw_reg, bsw_next, gdr_reg, gdr_next, conv_reg, conv_next, hiz_reg, hiz_next;
	logic assist_reg, assist_next, disch_reg, disch_next, hot_reg, hot_next;
	logic [15:0] eff_reg, eff_next, rev_mv_reg, rev_mv_next;
	logic [5:0] msp_reg;
	logic [7:0] rcur_reg;
	logic ok_oe_reg;

	// timers: forward power-up delay and reverse start delay
	logic [cms_pkg::MS_W-1:0] fwd_ms, rev_ms;
	logic rev_cond;
	cms_ms_timer #(.P_CYC_PER_MS(P_CYC_PER_MS)) u_fwd_timer (
		.i_clk(i_clk),
		.i_rst_n(rst_n),
		.i_run(vbus_on), // drop restarts the count
		.o_ms(fwd_ms)
	);
	cms_ms_timer #(.P_CYC_PER_MS(P_CYC_PER_MS)) u_rev_timer (
		.i_clk(i_clk),
		.i_rst_n(rst_n),
		.i_run(rev_cond),
		.o_ms(rev_ms)
	);

	// reverse enable qualifiers; a loaded cell configuration stands for a valid battery voltage
	assign rev_cond = rev_pin && rev_sel_reg && assist_off_reg && vbus_off && cells_done_reg;

	// next-state logic for all control state
	always_comb begin
		logic batt_only, assist_ok, fwd_ok, hiz, over;
		logic [15:0] th1_mv, th2_mv;
		{batt_only, assist_ok, fwd_ok, hiz, over} = '0;
		th1_mv = cms_pkg::TH1_BASE_MV + cms_pkg::TH1_STEP_MV * {12'h000, i_first_droop_threshold};
		th2_mv = cms_pkg::TH2_BASE_MV + cms_pkg::TH2_STEP_MV * {14'h0000, i_second_droop_threshold};
		{low_power_next, assist_off_next, rev_sel_next, hiz_bit_next, range_next, ok_rev_next, feat_next} =
			{low_power_reg, assist_off_reg, rev_sel_reg, hiz_bit_reg, range_reg, ok_rev_reg, feat_reg};
		pu_next = pu_reg;
		{reg6_next, conv_fwd_next, iin_next, floor_next, cells_done_next, cells_next} =
			{reg6_reg, conv_fwd_reg, iin_reg, floor_reg, cells_done_reg, cells_reg};
		{chg_next, sov_next, bat_pres_next} = {chg_reg, sov_reg, bat_pres_reg};
		if (i_cfg_wr) begin
			low_power_next = i_cfg_low_power;
			assist_off_next = i_cfg_assist_off; // host exit path
			rev_sel_next = i_cfg_reverse_sel;
			hiz_bit_next = i_cfg_hiz;
			range_next = i_cfg_reverse_range;
			ok_rev_next = i_cfg_ok_in_reverse;
			feat_next = i_cfg_feature_en;
		end
		// battery-only assist mode; host has set limits and thresholds beforehand
		batt_only = vbat_ok && !vbus_on;
		assist_ok = !assist_off_reg && !rev_sel_reg && mode_pin && batt_only;
		// fault sets the exit bit and beats a simultaneous host clear
		if (assist_ok && fault)
			assist_off_next = 1'b1;
		if (i_iin_wr)
			iin_next = i_iin_ma;
		// DC power-up sequence; any VBUS drop aborts it
		hiz = lim_low || hiz_bit_reg;
		if (!vbus_on) begin
			pu_next = cms_pkg::PU_OFF;
			reg6_next = 1'b0;
			conv_fwd_next = 1'b0;
		end else begin
			case (pu_reg)
				cms_pkg::PU_OFF: pu_next = cms_pkg::PU_WAIT;
				cms_pkg::PU_WAIT: begin
					if (fwd_ms >= cms_pkg::T_REG_ON_MS) begin
						reg6_next = 1'b1;
						pu_next = cms_pkg::PU_SETUP;
					end
				end
				cms_pkg::PU_SETUP: begin
					if (fwd_ms >= cms_pkg::T_CONV_ON_MS && cells_done_reg) begin
						over = i_vbus_noload_mv < cms_pkg::FLOOR_OFFSET_MV;
						floor_next = over ? 16'h0000 : i_vbus_noload_mv - cms_pkg::FLOOR_OFFSET_MV;
						conv_fwd_next = 1'b1;
						pu_next = cms_pkg::PU_RUN;
					end
				end
				cms_pkg::PU_RUN: pu_next = cms_pkg::PU_RUN;
				default: pu_next = cms_pkg::PU_OFF;
			endcase
		end
		// ok rising outside reverse loads the default input limit, ahead of the cell step
		fwd_ok = reg6_reg && vbus_on && vbus_below_ovp && !fault;
		ok_next = fwd_ok || (rev_run_reg && ok_rev_reg);
		if (ok_next && !ok_reg && !rev_run_reg)
			iin_next = cms_pkg::IIN_DEFAULT_MA;
		// cell configuration once the analog supply is up
		if (avdd_rdy && !cells_done_reg) begin
			cells_done_next = 1'b1;
			if (i_cell_pin_pct >= cms_pkg::CELL4_MIN_PCT) begin
				cells_next = 3'h4;
				chg_next = cms_pkg::CHG4_MV;
				sov_next = cms_pkg::SOV4_MV;
			end else if (i_cell_pin_pct >= cms_pkg::CELL3_MIN_PCT) begin
				cells_next = 3'h3;
				chg_next = cms_pkg::CHG3_MV;
				sov_next = cms_pkg::SOV3_MV;
			end else if (i_cell_pin_pct >= cms_pkg::CELL2_MIN_PCT) begin
				cells_next = 3'h2;
				chg_next = cms_pkg::CHG2_MV;
				sov_next = cms_pkg::SOV2_MV;
			end else begin
				cells_next = 3'h1;
				chg_next = cms_pkg::CHG1_MV;
				sov_next = cms_pkg::SOV1_MV;
			end
		end
		if (!avdd_rdy)
			cells_done_next = 1'b0;
		// battery presence with hysteresis
		if (i_cell_pin_pct > cms_pkg::BAT_PRES_RISE_PCT)
			bat_pres_next = 1'b1;
		else if (i_cell_pin_pct < cms_pkg::BAT_PRES_FALL_PCT)
			bat_pres_next = 1'b0;
		// reverse start after the qualifiers held long enough
		rev_run_next = rev_cond && (rev_ms >= cms_pkg::T_REV_ON_MS);
		// outputs
		bsw_next = batt_only;
		gdr_next = !low_power_reg || hiz || reg6_reg;
		hiz_next = hiz && vbus_on;
		// hi-z parks the converter; battery overvoltage halts reverse switching
		conv_next = !hiz && (conv_fwd_reg || (rev_run_reg && !bat_ovp));
		assist_next = assist_ok;
		disch_next = assist_ok && (i_system_rail_mv < th1_mv);
		hot_next = assist_ok && (i_system_rail_mv < th2_mv);
		eff_next = (i_limit_pin_ma < iin_reg) ? i_limit_pin_ma : iin_reg;
		rev_mv_next = (range_reg ? cms_pkg::REV_BASE_MV : cms_pkg::REV_BASE_MV + cms_pkg::REV_OFFSET_MV)
			+ cms_pkg::REV_LSB_MV * {4'h0, i_reverse_voltage_code};
	end

	// register stage; control bits take documented reset values
	always_ff @(posedge i_clk or negedge rst_n) begin
		if (!rst_n) begin
			low_power_reg <= cms_pkg::LOW_POWER_RST;
			assist_off_reg <= cms_pkg::ASSIST_OFF_RST;
			pu_reg <= cms_pkg::PU_OFF;
			iin_reg <= cms_pkg::IIN_DEFAULT_MA;
			ok_oe_reg <= 1'b1; // ok pin held low through reset
			{rev_sel_reg, hiz_bit_reg, range_reg, ok_rev_reg, feat_reg, reg6_reg, conv_fwd_reg, ok_reg} <= '0;
			{floor_reg, cells_done_reg, cells_reg, chg_reg, sov_reg, bat_pres_reg, rev_run_reg} <= '0;
			{bsw_reg, gdr_reg, conv_reg, hiz_reg, assist_reg, disch_reg, hot_reg, eff_reg, rev_mv_reg} <= '0;
			{msp_reg, rcur_reg} <= '0;
		end else begin
			{low_power_reg, assist_off_reg, rev_sel_reg, hiz_bit_reg, range_reg, ok_rev_reg, feat_reg} <=
				{low_power_next, assist_off_next, rev_sel_next, hiz_bit_next, range_next, ok_rev_next, feat_next};
			pu_reg <= pu_next;
			{reg6_reg, conv_fwd_reg, ok_reg, iin_reg, floor_reg, cells_done_reg, cells_reg} <=
				{reg6_next, conv_fwd_next, ok_next, iin_next, floor_next, cells_done_next, cells_next};
			{chg_reg, sov_reg, bat_pres_reg, rev_run_reg, bsw_reg, gdr_reg, conv_reg, hiz_reg} <=
				{chg_next, sov_next, bat_pres_next, rev_run_next, bsw_next, gdr_next, conv_next, hiz_next};
			{assist_reg, disch_reg, hot_reg, eff_reg, rev_mv_reg} <=
				{assist_next, disch_next, hot_next, eff_next, rev_mv_next};
			ok_oe_reg <= !ok_next; // oe high pulls the pin low
			{msp_reg, rcur_reg} <= {i_min_sys_point, i_reverse_current_code};
		end
	end

	// feature enables only take effect in performance mode
	logic [3:0] feat_out_reg;
	always_ff @(posedge i_clk or negedge rst_n) begin
		if (!rst_n)
			feat_out_reg <= '0;
		else
			feat_out_reg <= low_power_reg ? 4'h0 : feat_reg;
	end

	// output map; open-drain drive levels are tied low, only the enables move
	assign o_battery_switch_on = bsw_reg;
	assign o_gate_drive_regulator_en = gdr_reg;
	assign o_regulator_6v_en = reg6_reg;
	assign o_converter_en = conv_reg;
	assign o_low_power_mode = low_power_reg;
	assign o_hiz = hiz_reg;
	assign o_feature_en = feat_out_reg;
	assign o_capacitor_assist_mode = assist_reg;
	assign o_assist_discharge = disch_reg;
	assign o_min_sys_point = msp_reg; // held by the rail regulation loop
	assign o_assist_off_bit = assist_off_reg;
	assign o_processor_hot_alert_o = 1'b0;
	assign o_processor_hot_alert_oe = hot_reg;
	assign o_charger_ok_output_o = 1'b0;
	assign o_charger_ok_output_oe = ok_oe_reg; // released high only when ok
	assign o_iin_reg_ma = iin_reg;
	assign o_iin_eff_ma = eff_reg;
	assign o_input_voltage_floor_mv = floor_reg;
	assign o_cell_count = cells_reg;
	assign o_charge_voltage_mv = chg_reg;
	assign o_system_overvoltage_limit_mv = sov_reg;
	assign o_battery_present = bat_pres_reg;
	assign o_reverse_active = rev_run_reg;
	assign o_reverse_output_voltage_mv = rev_mv_reg;
	assign o_reverse_current_code = rcur_reg;
endmodule // cms_sequencer

// File: testbench/cms_host.sv
// host controller model driving control bits, limits and mode pins
`timescale 1ns/1ps
module cms_host (
	// clock
	input wire logic i_clk,
	// control-bit write
	output logic o_cfg_wr,
	output logic o_low_power,
	output logic o_assist_off,
	output logic o_reverse_sel,
	output logic o_hiz,
	output logic o_range,
	output logic o_ok_in_reverse,
	output logic [3:0] o_feature_en,
	// limits
	output logic o_iin_wr,
	output logic [15:0] o_iin_ma,
	output logic [11:0] o_voltage_code,
	output logic [5:0] o_min_sys,
	output logic [3:0] o_th1,
	output logic [1:0] o_th2,
	// pins
	output logic o_mode_pin,
	output logic o_rev_pin
);
	// everything idle; the device ignores control bits until a write strobe
	initial begin
		{o_cfg_wr, o_low_power, o_assist_off, o_reverse_sel, o_hiz, o_range, o_ok_in_reverse, o_feature_en} = '0;
		{o_iin_wr, o_iin_ma, o_voltage_code, o_min_sys, o_th1, o_th2, o_mode_pin, o_rev_pin} = '0;
	end
	// flags are {low power, assist off, reverse select, hi-z, range, ok in reverse}
	task automatic wr_cfg(input logic [5:0] f, input logic [3:0] fe);
		@(posedge i_clk);
		{o_low_power, o_assist_off, o_reverse_sel, o_hiz, o_range, o_ok_in_reverse} <= f;
		o_feature_en <= fe;
		o_cfg_wr <= 1'b1;
		@(posedge i_clk);
		o_cfg_wr <= 1'b0;
	endtask
	task automatic wr_iin(input logic [15:0] v);
		@(posedge i_clk);
		o_iin_ma <= v;
		o_iin_wr <= 1'b1;
		@(posedge i_clk);
		o_iin_wr <= 1'b0;
	endtask
	// voltage limit, minimum system point, then both droop thresholds, in that order
	task automatic set_assist(input logic [11:0] v, input logic [5:0] m, input logic [3:0] t1, input logic [1:0] t2);
		@(posedge i_clk) o_voltage_code <= v;
		@(posedge i_clk) o_min_sys <= m;
		@(posedge i_clk) o_th1 <= t1;
		@(posedge i_clk) o_th2 <= t2;
	endtask
	task automatic pins(input logic m, input logic r);
		@(posedge i_clk);
		o_mode_pin <= m;
		o_rev_pin <= r;
	endtask
endmodule // cms_host

// File: testbench/cms_sequencer_asserts.sv
// port-level assertion checker for the charger mode sequencer
`timescale 1ns/1ps
module cms_sequencer_asserts (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_rst_n,
	// watched inputs
	input wire logic i_fault_any,
	input wire logic [15:0] i_system_rail_mv,
	input wire logic [15:0] i_limit_pin_ma,
	input wire logic [3:0] i_first_droop_threshold,
	input wire logic [1:0] i_second_droop_threshold,
	// watched outputs
	input wire logic o_gate_drive_regulator_en,
	input wire logic o_converter_en,
	input wire logic o_low_power_mode,
	input wire logic o_hiz,
	input wire logic o_capacitor_assist_mode,
	input wire logic o_assist_discharge,
	input wire logic o_assist_off_bit,
	input wire logic o_processor_hot_alert_oe,
	input wire logic o_charger_ok_output_oe,
	input wire logic [15:0] o_iin_reg_ma,
	input wire logic [15:0] o_iin_eff_ma,
	input wire logic o_reverse_active
);
	logic [2:0] up_reg;
	logic [2:0] up_next;
	logic rdy;
	logic [15:0] th1_mv;
	logic [15:0] th2_mv;
	// the internal reset trails the pin by two flops, so hold off a few cycles
	always_comb begin
		up_next = (up_reg == 3'h7) ? up_reg : up_reg + 3'h1;
	end
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			up_reg <= 3'h0;
		end else begin
			up_reg <= up_next;
		end
	end
	// droop levels in mV
	assign rdy = (up_reg > 3'h4);
	assign th1_mv = cms_pkg::TH1_BASE_MV + cms_pkg::TH1_STEP_MV * {12'h000, i_first_droop_threshold};
	assign th2_mv = cms_pkg::TH2_BASE_MV + cms_pkg::TH2_STEP_MV * {14'h0000, i_second_droop_threshold};
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);
	// fault seen long enough to pass the synchroniser and the bit register
	sequence s_fault_seen; i_fault_any [*4]; endsequence
	sequence s_assist_hit; o_capacitor_assist_mode ##1 s_fault_seen; endsequence
	property p_perf_reg; (rdy && !o_low_power_mode) [*2] |-> o_gate_drive_regulator_en; endproperty
	a_perf_reg: assert property (p_perf_reg)
		else $error("gate drive off in performance mode");
	property p_discharge; rdy && o_capacitor_assist_mode && $stable(i_system_rail_mv) && $stable(th1_mv)
		|-> o_assist_discharge == (i_system_rail_mv < th1_mv); endproperty
	a_discharge: assert property (p_discharge)
		else $error("discharge does not follow first threshold");
	property p_alert; rdy && o_capacitor_assist_mode && $stable(i_system_rail_mv) && $stable(th2_mv)
		|-> o_processor_hot_alert_oe == (i_system_rail_mv < th2_mv); endproperty
	a_alert: assert property (p_alert)
		else $error("alert does not follow second threshold");
	property p_assist_gate; (rdy && o_assist_off_bit) [*2] |-> !o_capacitor_assist_mode; endproperty
	a_assist_gate: assert property (p_assist_gate)
		else $error("assist active with assist-off bit set");
	property p_fault_exit; rdy ##0 s_assist_hit |-> o_assist_off_bit; endproperty
	a_fault_exit: assert property (p_fault_exit)
		else $error("fault in assist did not set assist-off bit");
	property p_iin_load; rdy && $fell(o_charger_ok_output_oe) && !o_reverse_active
		|-> ##[0:1] o_iin_reg_ma == cms_pkg::IIN_DEFAULT_MA; endproperty
	a_iin_load: assert property (p_iin_load)
		else $error("input limit not loaded with default on ok");
	property p_eff_min; rdy && $stable(i_limit_pin_ma) && $stable(o_iin_reg_ma)
		|-> o_iin_eff_ma == ((i_limit_pin_ma < o_iin_reg_ma) ? i_limit_pin_ma : o_iin_reg_ma); endproperty
	a_eff_min: assert property (p_eff_min)
		else $error("effective limit is not the lower one");
	property p_hiz; rdy && o_hiz |-> !o_converter_en && o_gate_drive_regulator_en; endproperty
	a_hiz: assert property (p_hiz)
		else $error("converter or regulator wrong in hi-z");
endmodule // cms_sequencer_asserts

bind cms_sequencer cms_sequencer_asserts chk_u (.*);

// File: testbench/tb_cms_sequencer.sv
// self-checking bench for the charger mode sequencer
`timescale 1ns/1ps
module tb_cms_sequencer;
	localparam int MS = 10;
	localparam logic [6:0] PCT [4] = '{7'h4B, 7'h37, 7'h28, 7'h19};
	localparam logic [15:0] CHV [4] = '{16'h41A0, 16'h3130, 16'h20D0, 16'h1060};
	localparam logic [15:0] SOV [4] = '{16'h4C2C, 16'h4C2C, 16'h2EE0, 16'h1388};
	localparam logic [6:0] BP [4] = '{7'h10, 7'h0E, 7'h10, 7'h14};
	logic i_clk = 1'b0;
	logic i_rst_n = 1'b0;
	logic vbat_ok = 1'b0, vbus_on = 1'b0, ovp_ok = 1'b1, bus_low = 1'b1, fault = 1'b0, bovp = 1'b0, lim_hiz = 1'b0;
	logic [15:0] system_rail = 16'h1B58, lim_ma = 16'h1388;
	logic [6:0] pct = 7'h4B;
	int n_fail = 0, checked = 0, n_cyc = 0;
	wire cwr, clp, cao, crs, chz, crg, cok, iwr, mpin, rpin;
	wire [3:0] cfe, th1;
	wire [15:0] iin;
	wire [11:0] vcode;
	wire [5:0] msys;
	wire [1:0] th2;
	wire bsw, gdr, r6v, cnv, lpm, hz, asm, dis, aof, alr, okz, pres, rva;
	wire [3:0] fen;
	wire [5:0] msp;
	wire [15:0] iir, iie, flr, chv, sov, rvm;
	wire [2:0] ccn;
	wire [7:0] rvc;
	// 250 MHz clock
	always #2 i_clk = ~i_clk;
	cms_host host_u (.i_clk(i_clk), .o_cfg_wr(cwr), .o_low_power(clp), .o_assist_off(cao), .o_reverse_sel(crs),
		.o_hiz(chz), .o_range(crg), .o_ok_in_reverse(cok), .o_feature_en(cfe), .o_iin_wr(iwr), .o_iin_ma(iin),
		.o_voltage_code(vcode), .o_min_sys(msys), .o_th1(th1), .o_th2(th2), .o_mode_pin(mpin), .o_rev_pin(rpin));
	cms_sequencer #(.P_CYC_PER_MS(MS)) dut_u (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_vbat_above_release(vbat_ok),
		.i_vbus_above_conv_en(vbus_on), .i_vbus_below_ovp(ovp_ok), .i_vbus_below_conv_off(bus_low),
		.i_fault_any(fault), .i_battery_overvoltage_trip(bovp), .i_limit_pin_below_hiz(lim_hiz),
		.i_analog_supply_ready(1'b1), .i_reverse_assist_mode_pin(mpin), .i_reverse_enable_pin(rpin),
		.i_vbus_noload_mv(16'h4E20), .i_system_rail_mv(system_rail), .i_limit_pin_ma(lim_ma), .i_cell_pin_pct(pct),
		.i_cfg_wr(cwr), .i_cfg_low_power(clp), .i_cfg_assist_off(cao), .i_cfg_reverse_sel(crs), .i_cfg_hiz(chz),
		.i_cfg_reverse_range(crg), .i_cfg_ok_in_reverse(cok), .i_cfg_feature_en(cfe), .i_iin_wr(iwr),
		.i_iin_ma(iin), .i_reverse_voltage_code(vcode), .i_reverse_current_code(8'h5A), .i_min_sys_point(msys),
		.i_first_droop_threshold(th1), .i_second_droop_threshold(th2), .o_battery_switch_on(bsw),
		.o_gate_drive_regulator_en(gdr), .o_regulator_6v_en(r6v), .o_converter_en(cnv), .o_low_power_mode(lpm),
		.o_hiz(hz), .o_feature_en(fen), .o_capacitor_assist_mode(asm), .o_assist_discharge(dis),
		.o_min_sys_point(msp), .o_assist_off_bit(aof), .o_processor_hot_alert_o(), .o_processor_hot_alert_oe(alr),
		.o_charger_ok_output_o(), .o_charger_ok_output_oe(okz), .o_iin_reg_ma(iir), .o_iin_eff_ma(iie),
		.o_input_voltage_floor_mv(flr), .o_cell_count(ccn), .o_charge_voltage_mv(chv),
		.o_system_overvoltage_limit_mv(sov), .o_battery_present(pres), .o_reverse_active(rva),
		.o_reverse_output_voltage_mv(rvm), .o_reverse_current_code(rvc));
	task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		checked++;
		if (seen !== exp) begin
			n_fail++;
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// waits end on a falling edge so outputs have settled before sampling
	task automatic cyc(input int n);
		repeat (n) @(posedge i_clk);
		@(negedge i_clk);
	endtask
	task automatic rst;
		@(posedge i_clk) i_rst_n <= 1'b0;
		repeat (10) @(posedge i_clk);
		i_rst_n <= 1'b1;
		cyc(6);
	endtask
	task automatic end_of_test;
		$display("checked %0d n_fail %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	// hang guard well beyond the roughly 2300 cycles the sequence needs
	always @(posedge i_clk) begin
		n_cyc++;
		if (n_cyc == 8000) begin
			n_fail++;
			end_of_test();
		end
	end
	initial begin
		for (int i = 0; i < 4; i++) begin
			pct <= PCT[i];
			rst();
			chk("cells", 16'(ccn), 16'(4 - i));
			chk("charge_v", chv, CHV[i]);
			chk("sys_ovp", sov, SOV[i]);
		end
		chk("low_power", lpm, 16'h1);
		chk("gate_drive", gdr, 16'h0);
		chk("iin_reg", iir, cms_pkg::IIN_DEFAULT_MA);
		chk("bat_switch", bsw, 16'h0);
		for (int i = 0; i < 4; i++) begin
			@(posedge i_clk) pct <= BP[i];
			cyc(4);
			chk("present", pres, 16'(i != 1 && i != 2));
		end
		@(posedge i_clk) vbat_ok <= 1'b1;
		cyc(5);
		chk("bat_switch", bsw, 16'h1);
		$display("done reset and battery");
		host_u.wr_cfg(6'h10, 4'hF);
		cyc(4);
		chk("gate_drive", gdr, 16'h1);
		chk("features", fen, 16'hF);
		host_u.wr_cfg(6'h30, 4'hF);
		cyc(4);
		chk("features", fen, 16'h0);
		chk("gate_drive", gdr, 16'h0);
		$display("done modes");
		host_u.set_assist(12'h100, 6'h2A, 4'h3, 2'h1);
		host_u.wr_cfg(6'h00, 4'h0);
		host_u.pins(1'b1, 1'b0);
		cyc(5);
		chk("assist", asm, 16'h1);
		chk("min_sys", msp, 16'h2A);
		@(posedge i_clk) system_rail <= 16'h17D4;
		cyc(3);
		chk("discharge", dis, 16'h1);
		chk("alert", alr, 16'h0);
		@(posedge i_clk) system_rail <= 16'h173E;
		cyc(3);
		chk("alert", alr, 16'h1);
		@(posedge i_clk) system_rail <= 16'h1B58;
		host_u.pins(1'b0, 1'b0);
		cyc(5);
		chk("assist", asm, 16'h0);
		host_u.pins(1'b1, 1'b0);
		host_u.wr_cfg(6'h10, 4'h0);
		cyc(4);
		chk("assist", asm, 16'h0);
		host_u.wr_cfg(6'h00, 4'h0);
		cyc(4);
		chk("assist", asm, 16'h1);
		@(posedge i_clk) fault <= 1'b1;
		cyc(6);
		chk("assist_off", aof, 16'h1);
		chk("assist", asm, 16'h0);
		@(posedge i_clk) fault <= 1'b0;
		host_u.pins(1'b0, 1'b0);
		$display("done assist");
		host_u.wr_iin(16'h03E8);
		@(posedge i_clk) vbus_on <= 1'b1;
		cyc(30 * MS);
		@(posedge i_clk) vbus_on <= 1'b0;
		cyc(2 * MS);
		@(posedge i_clk) vbus_on <= 1'b1;
		cyc(48 * MS);
		chk("reg_6v", r6v, 16'h0);
		chk("ok_oe", okz, 16'h1);
		cyc(4 * MS);
		chk("reg_6v", r6v, 16'h1);
		chk("ok_oe", okz, 16'h0);
		chk("iin_reg", iir, cms_pkg::IIN_DEFAULT_MA);
		@(posedge i_clk) lim_ma <= 16'h07D0;
		cyc(3);
		chk("iin_eff", iie, 16'h07D0);
		cyc(95 * MS);
		chk("conv", cnv, 16'h0);
		cyc(5 * MS);
		chk("conv", cnv, 16'h1);
		chk("floor", flr, 16'h4920);
		@(posedge i_clk) fault <= 1'b1;
		cyc(5);
		chk("ok_oe", okz, 16'h1);
		@(posedge i_clk) fault <= 1'b0;
		lim_hiz <= 1'b1;
		cyc(5);
		chk("hiz", hz, 16'h1);
		chk("conv", cnv, 16'h0);
		@(posedge i_clk) lim_hiz <= 1'b0;
		host_u.wr_cfg(6'h14, 4'h0);
		cyc(4);
		chk("hiz", hz, 16'h1);
		chk("gate_drive", gdr, 16'h1);
		$display("done power-up");
		@(posedge i_clk) vbus_on <= 1'b0;
		host_u.wr_cfg(6'h19, 4'h0);
		host_u.pins(1'b0, 1'b1);
		cyc(8 * MS);
		chk("rev_active", rva, 16'h0);
		cyc(4 * MS);
		chk("rev_active", rva, 16'h1);
		chk("conv", cnv, 16'h1);
		chk("ok_oe", okz, 16'h0);
		chk("rev_mv", rvm, 16'h18B8);
		chk("rev_cur", rvc, 16'h5A);
		@(posedge i_clk) bovp <= 1'b1;
		cyc(5);
		chk("conv", cnv, 16'h0);
		@(posedge i_clk) bovp <= 1'b0;
		host_u.pins(1'b0, 1'b0);
		cyc(5);
		chk("rev_active", rva, 16'h0);
		host_u.wr_cfg(6'h1A, 4'h0);
		host_u.pins(1'b0, 1'b1);
		cyc(12 * MS);
		chk("ok_oe", okz, 16'h1);
		chk("rev_mv", rvm, 16'h13B8);
		$display("done reverse");
		end_of_test();
	end
endmodule // tb_cms_sequencer
